// file: design/ubc_map.svh
/*
 Register map, field positions, reset values and timing constants of the
 usb bus control block. Assumes a 40 MHz system clock and an AXI4-Lite
 register bus with 32-bit data, one register per aligned word.
*/
`ifndef UBC_MAP_SVH
`define UBC_MAP_SVH
`define UBC_A_CTL      6'h00
`define UBC_A_TRCTL    6'h04
`define UBC_A_STAT     6'h08
`define UBC_A_EPCTL    6'h0c
`define UBC_A_BUS_ENGINE_SUMMARY_FLAG    6'h10
`define UBC_A_SIEIE    6'h14
`define UBC_A_MAINIF   6'h18
`define UBC_A_MAINIE   6'h1c
`define UBC_A_DMA      6'h20
`define UBC_A_EVT      6'h24
// control bits
`define UBC_B_BUSDIS   7
`define UBC_B_ANEG     6
`define UBC_B_NONJEN   5
`define UBC_B_JEN      4
`define UBC_B_WAKE     3
`define UBC_B_EN       0
`define UBC_B_PULLUP   7
`define UBC_B_VBUS     7
`define UBC_B_FS       6
`define UBC_B_NAKSET   7
`define UBC_B_STLSET   6
`define UBC_B_ALLCLR   5
`define UBC_B_EP0CLR   0
// bus engine flags
`define UBC_F_NONJ     0
`define UBC_F_RESET    1
`define UBC_F_SUSP     2
`define UBC_F_J        3
`define UBC_F_SIE      0
`define UBC_MODE_RST   2'h1
`define UBC_LS_J       2'h1
`define UBC_LS_SE0     2'h0
// timing: 3 ms idle, 2.5 us se0
`define UBC_CLK_HZ     40000000
`define UBC_SUSP_US    3000
`define UBC_RST_NS     2500
`define UBC_SUSP_CYC   ((`UBC_SUSP_US * (`UBC_CLK_HZ / 1000000)))
`define UBC_RST_CYC    ((`UBC_RST_NS * (`UBC_CLK_HZ / 1000000)) / 1000)
`endif

// file: design/ubc_pkg.sv
/*
 Types for the usb bus control block. Assumes ubc_map.svh is included by
 the design file that uses it.
*/
package ubc_pkg;
   typedef enum logic [1:0] {
      UBC_BUS_ACTIVE,
      UBC_BUS_SUSP,
      UBC_BUS_RESET
   } ubc_bus_e;

   typedef struct packed {
      logic [5:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } ubc_wreq_s;

   typedef struct packed {
      logic [7:0]  ctl;
      logic [7:0]  trctl;
      logic [3:0]  sie_if;
      logic [3:0]  sie_ie;
      logic [0:0]  main_if;
      logic [0:0]  main_ie;
      logic [3:0]  dma_en_wr;
      logic [3:0]  dma_en_rd;
      logic        dma_wr_flag;
      logic        dma_rd_flag;
      logic [7:0]  ep_pulse;
      logic [15:0] prev_space;
      logic [15:0] prev_data;
      logic [17:0] idle_cnt;
      logic [7:0]  se0_cnt;
      ubc_bus_e    bus;
      logic        aw_got;
      logic        w_got;
      ubc_wreq_s   wr;
      logic        bvalid;
      logic        rvalid;
      logic [31:0] rdata;
   } ubc_state_s;
endpackage : ubc_pkg

// file: design/ubc_bus_control.sv
/*
 Bus control and status logic of a full-speed usb device controller:
 interrupt summary, dma requests, reset/suspend/j/non-j detection, remote
 wakeup, transceiver mode and global endpoint controls, over AXI4-Lite.
 Assumes an AXI4-Lite master, synchronous pin inputs and 40 MHz aclk.
*/
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`include "ubc_map.svh"

module ubc_bus_control
   import ubc_pkg::*;
#(
   parameter int NCH      = 4,
   parameter int SUSP_CYC = `UBC_SUSP_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [5:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        vbus_in,
   input  wire logic        dp_in,
   input  wire logic        dm_in,
   input  wire logic [15:0] free_space_count,
   input  wire logic [15:0] valid_data_count,
   output logic             irq,
   output logic [NCH-1:0]   dma_req_wr,
   output logic [NCH-1:0]   dma_req_rd,
   output logic             drive_k,
   output logic             dplus_pullup_enable,
   output logic [1:0]       transceiver_mode,
   output logic             controller_enable,
   output logic             all_nak_force,
   output logic             all_stall_force,
   output logic             all_fifo_clear,
   output logic             control_fifo_clear
);
   localparam logic [17:0] SUSP_N = 18'(SUSP_CYC);
   localparam logic [7:0]  RST_N  = 8'(`UBC_RST_CYC);

   ubc_state_s q;
   ubc_state_s d;
   logic [1:0] line_state;
   logic       bus_active;
   logic       det_on;
   logic       wr_fire;
   logic       rd_fire;
   logic [7:0] stat_rd;
   logic [3:0] sie_set;
   logic       susp_evt;
   logic       rst_evt;

   // line state bits: d+ high, d- low reads 0x1 (j)
   assign line_state = {dm_in, dp_in};
   assign stat_rd = {vbus_in, 1'b1, 4'h0, line_state};
   assign bus_active = (line_state != `UBC_LS_J);
   assign det_on = q.ctl[`UBC_B_EN] & ~q.ctl[`UBC_B_BUSDIS];

   // handshake outputs are combinational; one transfer in flight each way
   assign s_axi_awready = ~q.aw_got & ~q.bvalid;
   assign s_axi_wready  = ~q.w_got & ~q.bvalid;
   assign s_axi_arready = ~q.rvalid;
   assign wr_fire = (q.aw_got | s_axi_awvalid) & (q.w_got | s_axi_wvalid)
                    & ~q.bvalid;
   assign rd_fire = s_axi_arvalid & ~q.rvalid;

   // detector events: timers run only while detection is on
   assign susp_evt = det_on & (q.bus != UBC_BUS_SUSP)
                     & (q.idle_cnt == SUSP_N - 18'h1) & ~bus_active;
   assign rst_evt  = det_on & (q.bus != UBC_BUS_RESET)
                     & (q.se0_cnt == RST_N) & (line_state == `UBC_LS_SE0);
   always_comb begin
      sie_set = 4'h0;
      sie_set[`UBC_F_SUSP]  = susp_evt;
      sie_set[`UBC_F_RESET] = rst_evt;
      sie_set[`UBC_F_NONJ]  = q.ctl[`UBC_B_NONJEN]
                              & (line_state != `UBC_LS_J);
      sie_set[`UBC_F_J]     = q.ctl[`UBC_B_JEN]
                              & (line_state == `UBC_LS_J);
   end

   // next state
   always_comb begin
      ubc_wreq_s w;
      logic [31:0] wd;
      d = q;
      w = q.wr;
      wd = 32'h0;
      // address and data may land on different edges; each is held
      if (s_axi_awvalid & s_axi_awready) begin
         w.addr = s_axi_awaddr;
         d.aw_got = 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
         w.data = s_axi_wdata;
         w.strb = s_axi_wstrb;
         d.w_got = 1'b1;
      end
      d.wr = w;
      wd = w.data;
      d.ep_pulse = 8'h0; // one-cycle self clearing pulses
      // suspend and reset timers
      if (!det_on || bus_active)
         d.idle_cnt = 18'h0;
      else if (q.idle_cnt != SUSP_N - 18'h1)
         d.idle_cnt = q.idle_cnt + 18'h1;
      if (!det_on || line_state != `UBC_LS_SE0)
         d.se0_cnt = 8'h0;
      else if (q.se0_cnt != RST_N)
         d.se0_cnt = q.se0_cnt + 8'h1;
      if (susp_evt)
         d.bus = UBC_BUS_SUSP;
      else if (rst_evt)
         d.bus = UBC_BUS_RESET;
      else if (bus_active && line_state != `UBC_LS_SE0)
         d.bus = UBC_BUS_ACTIVE;
      // dma flags while free space or valid data is nonzero
      d.prev_space = free_space_count;
      d.prev_data  = valid_data_count;
      d.dma_wr_flag = (free_space_count != 16'h0);
      d.dma_rd_flag = (valid_data_count != 16'h0);
      // register writes
      if (wr_fire) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         if (w.strb[0]) begin
            case (w.addr)
               `UBC_A_CTL:    d.ctl = {wd[7:3], 2'b00, wd[0]};
               `UBC_A_TRCTL:  d.trctl = {wd[7], 5'h00, wd[1:0]};
               `UBC_A_EPCTL:  d.ep_pulse = {wd[7:5], 4'h0, wd[0]};
               `UBC_A_BUS_ENGINE_SUMMARY_FLAG:  d.sie_if = q.sie_if & ~wd[3:0];
               `UBC_A_SIEIE:  d.sie_ie = wd[3:0];
               `UBC_A_MAINIF: d.main_if = q.main_if & ~wd[0:0];
               `UBC_A_MAINIE: d.main_ie = wd[0:0];
               `UBC_A_DMA:    begin
                  d.dma_en_wr = wd[3:0];
                  d.dma_en_rd = wd[11:8];
               end
               default:       d.bvalid = 1'b1;
            endcase
         end
      end
      // write response stands until the master takes it
      if (q.bvalid & s_axi_bready)
         d.bvalid = 1'b0;
      // hardware sets win over software clears
      d.sie_if = d.sie_if | sie_set;
      if (susp_evt & q.ctl[`UBC_B_ANEG])
         d.ctl[`UBC_B_NONJEN] = 1'b1;
      if (|(d.sie_if & d.sie_ie & sie_set) | |(q.sie_if & q.sie_ie & sie_set))
         d.main_if[`UBC_F_SIE] = 1'b1;
      if (|(sie_set & q.sie_ie))
         d.main_if[`UBC_F_SIE] = 1'b1;
      // reads
      if (rd_fire) begin
         d.rvalid = 1'b1;
         case (s_axi_araddr)
            `UBC_A_CTL:    d.rdata = {24'h0, q.ctl};
            `UBC_A_TRCTL:  d.rdata = {24'h0, q.trctl};
            `UBC_A_STAT:   d.rdata = {24'h0, stat_rd};
            `UBC_A_EPCTL:  d.rdata = 32'h0;
            `UBC_A_BUS_ENGINE_SUMMARY_FLAG:  d.rdata = {28'h0, q.sie_if};
            `UBC_A_SIEIE:  d.rdata = {28'h0, q.sie_ie};
            `UBC_A_MAINIF: d.rdata = {31'h0, q.main_if};
            `UBC_A_MAINIE: d.rdata = {31'h0, q.main_ie};
            `UBC_A_DMA:    d.rdata = {20'h0, q.dma_en_rd, 4'h0, q.dma_en_wr};
            `UBC_A_EVT:    d.rdata = {28'h0, 2'(q.bus), q.dma_rd_flag,
                                      q.dma_wr_flag};
            default:       d.rdata = 32'h0;
         endcase
      end
      // read data stands until the master takes it
      if (q.rvalid & s_axi_rready)
         d.rvalid = 1'b0;
   end

   // single state register; controller enable and mode reset as documented
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.trctl <= {6'h00, `UBC_MODE_RST};
         q.bus <= UBC_BUS_ACTIVE;
      end else begin
         q <= d;
      end
   end

   // outputs; only the wakeup k drive is held off until enabled
   assign irq = |(q.main_if & q.main_ie);
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_dma
         assign dma_req_wr[gi] = q.dma_wr_flag & q.dma_en_wr[gi];
         assign dma_req_rd[gi] = q.dma_rd_flag & q.dma_en_rd[gi];
      end
   endgenerate
   assign drive_k = q.ctl[`UBC_B_WAKE] & q.ctl[`UBC_B_EN];
   assign dplus_pullup_enable = q.trctl[`UBC_B_PULLUP];
   assign transceiver_mode = q.trctl[1:0];
   assign controller_enable = q.ctl[`UBC_B_EN];
   assign all_nak_force = q.ep_pulse[`UBC_B_NAKSET];
   assign all_stall_force = q.ep_pulse[`UBC_B_STLSET];
   assign all_fifo_clear = q.ep_pulse[`UBC_B_ALLCLR];
   assign control_fifo_clear = q.ep_pulse[`UBC_B_EP0CLR];
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = 2'b00;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = 2'b00;

   // checks
   a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      irq |-> (q.main_if[0] & q.main_ie[0])) else $error("irq ungated");
   a_sum_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      |(sie_set & q.sie_ie) |=> q.main_if[0]) else $error("no summary");
   a_dma_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      dma_req_wr[0] |-> q.dma_wr_flag & q.dma_en_wr[0])
      else $error("dma ungated");
   a_det_off: assert property (@(posedge aclk) disable iff (!aresetn)
      q.ctl[7] |-> !susp_evt && !rst_evt) else $error("detect on");
   a_susp_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      susp_evt |=> q.sie_if[2] && q.bus == UBC_BUS_SUSP)
      else $error("no suspend");
   a_rst_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      rst_evt |-> $past(line_state == 2'h0, 100)) else $error("short se0");
   a_nonj_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      sie_set[0] |-> q.ctl[5]) else $error("nonj ungated");
   a_nak_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      all_nak_force |=> !all_nak_force) else $error("nak stuck");
   a_wake_k: assert property (@(posedge aclk) disable iff (!aresetn)
      drive_k |-> q.ctl[3]) else $error("k without wakeup");
   c_suspend: cover property (@(posedge aclk) susp_evt);
   c_reset: cover property (@(posedge aclk) rst_evt);
   c_irq: cover property (@(posedge aclk) $rose(irq));
   c_nonj: cover property (@(posedge aclk) sie_set[`UBC_F_NONJ]);
   c_dma: cover property (@(posedge aclk) |dma_req_rd);

   // further checks; each one watches state the block drives itself,
   // so a broken gate or timer shows up without help from the bench

   // cpu request follows every enabled summary flag
   a_irq_on: assert property (@(posedge aclk) disable iff (!aresetn)
      |(q.main_if & q.main_ie) |-> irq)
      else $error("irq missing");

   // summary flag is set in the same cycle as the lower flag
   a_sum_now: assert property (@(posedge aclk) disable iff (!aresetn)
      |(sie_set & q.sie_ie) |-> d.main_if[`UBC_F_SIE])
      else $error("summary late");

   // write dma flag follows free space
   a_wr_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      free_space_count != 16'h0 |=> q.dma_wr_flag)
      else $error("no write dma flag");

   // no free space, no write dma flag
   a_wr_clr: assert property (@(posedge aclk) disable iff (!aresetn)
      free_space_count == 16'h0 |=> !q.dma_wr_flag)
      else $error("stale write dma flag");

   // read dma flag follows valid data
   a_rd_flag: assert property (@(posedge aclk) disable iff (!aresetn)
      valid_data_count != 16'h0 |=> q.dma_rd_flag)
      else $error("no read dma flag");

   // no valid data, no read dma flag
   a_rd_clr: assert property (@(posedge aclk) disable iff (!aresetn)
      valid_data_count == 16'h0 |=> !q.dma_rd_flag)
      else $error("stale read dma flag");

   // read request needs flag and channel enable
   a_rd_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      dma_req_rd[0] |-> q.dma_rd_flag & q.dma_en_rd[0])
      else $error("read dma ungated");

   // enabled channel sees the write request
   a_dma_on: assert property (@(posedge aclk) disable iff (!aresetn)
      q.dma_wr_flag & q.dma_en_wr[0] |-> dma_req_wr[0])
      else $error("write dma lost");

   // timers stay cleared while detection is off
   a_off_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      !det_on |=> q.idle_cnt == 18'h0 && q.se0_cnt == 8'h0)
      else $error("timer ran");

   // suspend only after the full idle count
   a_susp_cnt: assert property (@(posedge aclk) disable iff (!aresetn)
      susp_evt |-> q.idle_cnt == SUSP_N - 18'h1)
      else $error("early suspend");

   // reset only after the full se0 count
   a_rst_cnt: assert property (@(posedge aclk) disable iff (!aresetn)
      rst_evt |-> q.se0_cnt == RST_N)
      else $error("early reset");

   // reset detection sets its flag, even against a clear
   a_rst_set: assert property (@(posedge aclk) disable iff (!aresetn)
      rst_evt |=> q.sie_if[`UBC_F_RESET])
      else $error("no reset flag");

   // auto-negotiation starts off after reset
   a_aneg_rst: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> !q.ctl[`UBC_B_ANEG])
      else $error("aneg not reset");

   // suspend under auto-negotiation arms nonj detection
   a_aneg_sus: assert property (@(posedge aclk) disable iff (!aresetn)
      susp_evt & q.ctl[`UBC_B_ANEG] |=> q.ctl[`UBC_B_NONJEN])
      else $error("nonj not armed");

   // armed nonj detection flags a non-j line
   a_nonj_set: assert property (@(posedge aclk) disable iff (!aresetn)
      q.ctl[`UBC_B_NONJEN] && line_state != `UBC_LS_J |=> q.sie_if[0])
      else $error("nonj missed");

   // armed j detection flags a j line
   a_j_set: assert property (@(posedge aclk) disable iff (!aresetn)
      q.ctl[`UBC_B_JEN] && line_state == `UBC_LS_J |=> q.sie_if[3])
      else $error("j missed");

   // enabled j flag reaches the summary flag
   a_j_sum: assert property (@(posedge aclk) disable iff (!aresetn)
      q.ctl[`UBC_B_JEN] && line_state == `UBC_LS_J && q.sie_ie[3]
      |=> q.main_if[`UBC_F_SIE])
      else $error("j summary missed");

   // wakeup bit with the block enabled drives k
   a_k_on: assert property (@(posedge aclk) disable iff (!aresetn)
      q.ctl[`UBC_B_WAKE] && q.ctl[`UBC_B_EN] |-> drive_k)
      else $error("k missing");

   // a disabled block drives no k onto the bus
   a_en_halt: assert property (@(posedge aclk) disable iff (!aresetn)
      !controller_enable |-> !drive_k)
      else $error("k while disabled");

   // transceiver comes out of reset non-driving
   a_mode_rst: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> transceiver_mode == `UBC_MODE_RST)
      else $error("mode not reset");

   // status read shows vbus and the fixed full-speed bit
   a_stat_rd: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_fire && s_axi_araddr == `UBC_A_STAT |=> s_axi_rdata[`UBC_B_FS]
      && s_axi_rdata[`UBC_B_VBUS] == $past(vbus_in))
      else $error("status wrong");

   // status read shows the line state as sampled
   a_line_rd: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_fire && s_axi_araddr == `UBC_A_STAT
      |=> s_axi_rdata[1:0] == $past(line_state))
      else $error("line state wrong");

   // fifo clear strobes last one cycle
   a_clr_pls: assert property (@(posedge aclk) disable iff (!aresetn)
      all_fifo_clear |=> !all_fifo_clear)
      else $error("fifo clear stuck");

   // control fifo clear strobe lasts one cycle
   a_ep0_pls: assert property (@(posedge aclk) disable iff (!aresetn)
      control_fifo_clear |=> !control_fifo_clear)
      else $error("ep0 clear stuck");
endmodule // ubc_bus_control

// file: test/ubc_host_model.sv
/*
 Host side of the full-speed bus: drives d+, d- and vbus levels.
 Assumes the bench picks the line state; device k output wins.
*/
module ubc_host_model (
   input  wire logic       aclk,
   input  wire logic [1:0] line_cmd,
   input  wire logic       vbus_on,
   input  wire logic       drive_k,
   output logic            dp,
   output logic            dm,
   output logic            vbus
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle j with vbus low until the bench says otherwise
   initial {dp, dm, vbus} = 3'b100;
   // codes are {dm,dp}; a driven k overrides the host
   always @(posedge aclk) begin
      dp   <= drive_k ? 1'b0 : line_cmd[0];
      dm   <= drive_k ? 1'b1 : line_cmd[1];
      vbus <= vbus_on;
   end
endmodule // ubc_host_model

// file: test/ubc_bus_control_test.sv
/*
 Self-checking bench of the usb bus control block.
 Assumes the host model drives the pins; the bench is the axi master.
*/
`include "ubc_map.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end

module ubc_bus_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0, aresetn = 1'b0, vbus_on = 1'b0;
   logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb = 4'hf, dma_req_wr, dma_req_rd;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
   logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, transceiver_mode;
   logic [1:0]  line_cmd = 2'h1;
   logic [15:0] free_space_count = 16'h0, valid_data_count = 16'h0;
   logic        vbus_in, dp_in, dm_in, irq, drive_k, dplus_pullup_enable;
   logic        controller_enable, all_nak_force, all_stall_force;
   logic        all_fifo_clear, control_fifo_clear;
   int          err_total = 0, checks = 0, cyc = 0;
   int          n_nak = 0, n_stl = 0, n_all = 0, n_ep0 = 0;

   // short suspend count keeps the run brief
   ubc_bus_control #(.NCH(4), .SUSP_CYC(50)) u_ubc_bus_control (.aclk,
      .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .vbus_in, .dp_in, .dm_in, .free_space_count,
      .valid_data_count, .irq, .dma_req_wr, .dma_req_rd, .drive_k,
      .dplus_pullup_enable, .transceiver_mode, .controller_enable,
      .all_nak_force, .all_stall_force, .all_fifo_clear,
      .control_fifo_clear);

   ubc_host_model u_ubc_host_model (.aclk, .line_cmd, .vbus_on, .drive_k,
      .dp(dp_in), .dm(dm_in), .vbus(vbus_in));

   // 40 mhz clock
   always #12.5 aclk = ~aclk;

   task automatic close_out();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // pulse counters and watchdog; a hang counts as a mismatch
   always @(posedge aclk) begin
      cyc++;
      n_nak += all_nak_force;
      n_stl += all_stall_force;
      n_all += all_fifo_clear;
      n_ep0 += control_fifo_clear;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   task automatic cy(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic ln(input logic [1:0] c, input int n);
      @(posedge aclk);
      line_cmd <= c;
      cy(n);
   endtask

   // one write; the leading edge keeps bready from two assignments at once
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      `CHK("bresp", 2'h0, s_axi_bresp)
   endtask

   task automatic rd(input logic [5:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rv = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask

   task automatic t_reset();
      rd(`UBC_A_CTL);
      `CHK("ctl", 32'h0, rv)
      `CHK("aneg", 1'b0, rv[6])
      rd(`UBC_A_TRCTL);
      `CHK("trctl", 32'h1, rv)
      `CHK("en", 1'b0, controller_enable)
      rd(6'h3c);
      `CHK("unmapped", 32'h0, rv)
   endtask

   // every line code, vbus toggling along
   task automatic t_status();
      for (int i = 0; i < 4; i++) begin
         vbus_on <= i[0];
         ln(i[1:0], 3);
         rd(`UBC_A_STAT);
         `CHK("stat", {24'h0, i[0], 1'b1, 4'h0, i[1:0]}, rv)
         `CHK("line", i[1:0], rv[1:0])
      end
   endtask

   task automatic t_mode();
      for (int i = 2; i >= 0; i--) begin
         wr(`UBC_A_TRCTL, 32'h80 | i);
         `CHK("mode", i[1:0], transceiver_mode)
         `CHK("pullup", 1'b1, dplus_pullup_enable)
      end
   endtask

   task automatic t_dma();
      wr(`UBC_A_DMA, 32'h0402);
      `CHK("no space", 4'h0, dma_req_wr)
      free_space_count <= 16'h5;
      valid_data_count <= 16'h1;
      cy(3);
      `CHK("wr req", 4'h2, dma_req_wr)
      `CHK("rd req", 4'h4, dma_req_rd)
      wr(`UBC_A_DMA, 32'h0);
      `CHK("gated", 4'h0, dma_req_wr | dma_req_rd)
   endtask

   // idle j with auto-negotiation on raises suspend and the cpu request
   task automatic t_susp();
      wr(`UBC_A_SIEIE, 32'h4);
      wr(`UBC_A_MAINIE, 32'h1);
      ln(2'h1, 1);
      wr(`UBC_A_CTL, 32'h41);
      `CHK("early", 1'b0, irq)
      cy(70);
      rd(`UBC_A_BUS_ENGINE_SUMMARY_FLAG);
      `CHK("susp", 1'b1, rv[2])
      `CHK("summary", 1'b1, irq)
      rd(`UBC_A_CTL);
      `CHK("nonj en", 1'b1, rv[5])
      wr(`UBC_A_MAINIE, 32'h0);
      `CHK("masked", 1'b0, irq)
   endtask

   task automatic t_nonj();
      ln(2'h2, 4);
      rd(`UBC_A_BUS_ENGINE_SUMMARY_FLAG);
      `CHK("nonj", 1'b1, rv[0])
      wr(`UBC_A_CTL, 32'h81);
      wr(`UBC_A_BUS_ENGINE_SUMMARY_FLAG, 32'hf);
      rd(`UBC_A_BUS_ENGINE_SUMMARY_FLAG);
      `CHK("nonj off", 1'b0, rv[0])
   endtask

   task automatic t_j();
      wr(`UBC_A_SIEIE, 32'h8);
      wr(`UBC_A_MAINIF, 32'h1);
      wr(`UBC_A_CTL, 32'h91);
      ln(2'h1, 4);
      rd(`UBC_A_BUS_ENGINE_SUMMARY_FLAG);
      `CHK("j", 4'h8, rv[3:0])
      rd(`UBC_A_MAINIF);
      `CHK("j summary", 1'b1, rv[0])
   endtask

   // short se0 is ignored, long se0 is a reset unless detection is off
   task automatic t_rst();
      wr(`UBC_A_CTL, 32'h01);
      wr(`UBC_A_BUS_ENGINE_SUMMARY_FLAG, 32'hf);
      ln(2'h0, 80);
      ln(2'h1, 2);
      rd(`UBC_A_BUS_ENGINE_SUMMARY_FLAG);
      `CHK("short se0", 1'b0, rv[1])
      ln(2'h0, 110);
      rd(`UBC_A_BUS_ENGINE_SUMMARY_FLAG);
      `CHK("reset", 1'b1, rv[1])
      ln(2'h1, 2);
      wr(`UBC_A_CTL, 32'h81);
      wr(`UBC_A_BUS_ENGINE_SUMMARY_FLAG, 32'hf);
      ln(2'h0, 110);
      rd(`UBC_A_BUS_ENGINE_SUMMARY_FLAG);
      `CHK("reset off", 1'b0, rv[1])
   endtask

   task automatic t_wake();
      wr(`UBC_A_CTL, 32'h09);
      `CHK("enabled", 1'b1, controller_enable)
      `CHK("k on", 1'b1, drive_k)
      wr(`UBC_A_CTL, 32'h01);
      `CHK("k off", 1'b0, drive_k)
   endtask

   task automatic t_ep();
      wr(`UBC_A_EPCTL, 32'he1);
      wr(`UBC_A_EPCTL, 32'h20);
      rd(`UBC_A_EPCTL);
      `CHK("epctl", 32'h0, rv)
      `CHK("nak stl", 8'h11, {n_nak[3:0], n_stl[3:0]})
      `CHK("fifo clr", 8'h21, {n_all[3:0], n_ep0[3:0]})
   endtask

   // reset for 16 cycles, then each scenario in turn
   initial begin
      cy(16);
      aresetn <= 1'b1;
      t_reset();
      t_status();
      t_mode();
      t_dma();
      t_susp();
      t_nonj();
      t_j();
      t_rst();
      t_wake();
      t_ep();
      close_out();
   end
endmodule // ubc_bus_control_test
